/* src/fvpc_pkg.sv */
// Constants, register map and state type of the flash command sequencer.
// Functional notes
// - Clearing the completion flag launches the command; flag sets again when finished.
// - Code 0x01 blank-checks all program and data memory; failure sets both fault bits.
// - Code 0x01 raises access error and does not run unless index is 000.
// - Erase-verify: any read error or blank failure sets fault bits as specified.
// - Code 0x02 takes address from words 0 and 1, checks block; index 001.
// - Code 0x02 raises access error when address names no valid block.
// - Code 0x03 takes block byte, first phrase, phrase count; index must be 010.
// - Section check errors on misaligned start, invalid address, or crossing boundary.
// - Codes 0x03, 0x04, 0x06 raise access error when mode forbids them.
// - Code 0x04 fetches one-time phrase 0 to 7 into words 2 to 5.
// - One-time read errors on bad phrase index or index not 001.
// - During one-time read, program memory reads return invalid data.
// - Code 0x06 programs words 2 to 5 at address from words 0, 1; index 101.
// - Programmed phrase is read back and compared; errors set fault bits.
// - Program errors on bad or misaligned address; protected area sets protection flag.
// - Unsupported command code sets access error and is ignored.
package fvpc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_PINDEX = 4'h1;
  localparam logic [3:0] ADDR_PDATA = 4'h2;
  localparam logic [3:0] ADDR_CTRL = 4'h3;
  localparam logic [3:0] ADDR_PROT = 4'h4;

  localparam int BIT_CCF = 7;
  localparam int BIT_ACC = 5;
  localparam int BIT_PVIOL = 4;
  localparam int BIT_VF_ANY = 1;
  localparam int BIT_VF_UNC = 0;
  localparam int BIT_MODE_OK = 0;
  localparam int BIT_PROT_EN = 1;

  localparam logic MODE_OK_RESET = 1'b1;
  localparam logic PROT_EN_RESET = 1'b0;
  localparam logic [7:0] PROT_FLOOR_RESET = 8'hff;

  // ----------------------------------------------------------------------
  // Commands and parameter indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROGRAM = 8'h06;
  localparam logic [2:0] PIDX_VERIFY_ALL = 3'h0;
  localparam logic [2:0] PIDX_VERIFY_BLOCK = 3'h1;
  localparam logic [2:0] PIDX_VERIFY_SECTION = 3'h2;
  localparam logic [2:0] PIDX_READ_ONCE = 3'h1;
  localparam logic [2:0] PIDX_PROGRAM = 3'h5;
  localparam int NUM_PARAMS = 6;
  localparam logic [2:0] PIDX_LAST = 3'h5;
  localparam logic [15:0] ONCE_LAST = 16'h0007;

  // ----------------------------------------------------------------------
  // Memory layout
  // ----------------------------------------------------------------------
  localparam logic [23:0] EE_BASE = 24'h100000;
  localparam logic [23:0] EE_LAST = 24'h100ff8;
  localparam logic [23:0] PF_BASE = 24'hfe0000;
  localparam logic [23:0] PF_LAST = 24'hfffff8;
  localparam logic [23:0] PHRASE_STEP = 24'h000008;
  localparam logic [63:0] ERASED = 64'hffffffffffffffff;

  typedef enum {S_IDLE, S_WRITE, S_READ, S_WAIT, S_EVAL} fvpc_state_t;
  typedef enum {OP_VERIFY, OP_ONCE, OP_PROGRAM} fvpc_op_t;

  typedef struct packed {
    fvpc_state_t st;
    fvpc_op_t op;
    logic ccf;
    logic acc;
    logic pviol;
    logic vf_any;
    logic vf_unc;
    logic [2:0] pidx;
    logic [NUM_PARAMS-1:0][15:0] p;
    logic mode_ok;
    logic prot_en;
    logic [7:0] prot_floor;
    logic [23:0] addr;
    logic [23:0] last;
    logic two;
    logic mem_rd;
    logic mem_wr;
    logic ifr;
    logic rd_inval;
    logic [15:0] rdata;
  } fvpc_regs_t;

endpackage : fvpc_pkg

/* src/fvpc_top.sv */
// Command sequencer for verify, one-time read and phrase program operations.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fvpc_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic [23:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic MEM_IFR,
  output logic [63:0] MEM_WDATA,
  input wire logic [63:0] MEM_RDATA,
  input wire logic MEM_ERR,
  input wire logic MEM_FATAL,
  output logic READ_INVALID,
  output logic CMD_DONE
);

  fvpc_pkg::fvpc_regs_t s;
  fvpc_pkg::fvpc_regs_t next_s;

  logic [7:0] code;
  logic [23:0] gaddr;
  logic [24:0] sect_end;
  logic in_pf;
  logic in_ee;
  logic aligned;
  logic launch;
  logic bad;
  logic blank_fail;
  logic mismatch;

  // ----------------------------------------------------------------------
  // Launch-time decode and read-data compares
  // ----------------------------------------------------------------------
  always_comb begin
    code = s.p[0][15:8];
    gaddr = {s.p[0][7:0], s.p[1]};
    sect_end = 25'({1'b0, gaddr} + {6'h00, s.p[2], 3'h0} - {1'b0, fvpc_pkg::PHRASE_STEP});
    in_pf = (gaddr >= fvpc_pkg::PF_BASE) && (gaddr <= (fvpc_pkg::PF_LAST | 24'h000007));
    in_ee = (gaddr >= fvpc_pkg::EE_BASE) && (gaddr <= (fvpc_pkg::EE_LAST | 24'h000007));
    aligned = (gaddr[2:0] == 3'h0);
    blank_fail = (MEM_RDATA != fvpc_pkg::ERASED);
    mismatch = (MEM_RDATA != {s.p[2], s.p[3], s.p[4], s.p[5]});
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.mem_rd = 1'b0;
    next_s.mem_wr = 1'b0;
    next_s.rdata = 16'h0000;
    launch = 1'b0;
    bad = 1'b0;
    if (RD) begin
      case (ADDR)
        fvpc_pkg::ADDR_STATUS: begin
          next_s.rdata[fvpc_pkg::BIT_CCF] = s.ccf;
          next_s.rdata[fvpc_pkg::BIT_ACC] = s.acc;
          next_s.rdata[fvpc_pkg::BIT_PVIOL] = s.pviol;
          next_s.rdata[fvpc_pkg::BIT_VF_ANY] = s.vf_any;
          next_s.rdata[fvpc_pkg::BIT_VF_UNC] = s.vf_unc;
        end
        fvpc_pkg::ADDR_PINDEX: next_s.rdata = {13'h0000, s.pidx};
        fvpc_pkg::ADDR_PDATA: begin
          if (s.pidx <= fvpc_pkg::PIDX_LAST) begin
            next_s.rdata = s.p[s.pidx];
          end
        end
        fvpc_pkg::ADDR_CTRL: begin
          next_s.rdata[fvpc_pkg::BIT_MODE_OK] = s.mode_ok;
          next_s.rdata[fvpc_pkg::BIT_PROT_EN] = s.prot_en;
        end
        fvpc_pkg::ADDR_PROT: next_s.rdata = {8'h00, s.prot_floor};
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (WR) begin
      case (ADDR)
        fvpc_pkg::ADDR_STATUS: begin
          if (WDATA[fvpc_pkg::BIT_ACC]) begin
            next_s.acc = 1'b0;
          end
          if (WDATA[fvpc_pkg::BIT_PVIOL]) begin
            next_s.pviol = 1'b0;
          end
          // A launch with an error flag still pending is refused, so stale
          // errors can never be mistaken for results of the new command.
          launch = WDATA[fvpc_pkg::BIT_CCF] && s.ccf && !next_s.acc && !next_s.pviol;
        end
        fvpc_pkg::ADDR_PINDEX: next_s.pidx = WDATA[2:0];
        fvpc_pkg::ADDR_PDATA: begin
          if (s.ccf && s.pidx <= fvpc_pkg::PIDX_LAST) begin
            next_s.p[s.pidx] = WDATA;
          end
        end
        fvpc_pkg::ADDR_CTRL: begin
          next_s.mode_ok = WDATA[fvpc_pkg::BIT_MODE_OK];
          next_s.prot_en = WDATA[fvpc_pkg::BIT_PROT_EN];
        end
        fvpc_pkg::ADDR_PROT: next_s.prot_floor = WDATA[7:0];
        default: begin
        end
      endcase
    end
    if (launch) begin
      next_s.vf_any = 1'b0;
      next_s.vf_unc = 1'b0;
      next_s.op = fvpc_pkg::OP_VERIFY;
      next_s.two = 1'b0;
      next_s.ifr = 1'b0;
      next_s.addr = gaddr;
      next_s.st = fvpc_pkg::S_READ;
      case (code)
        fvpc_pkg::CMD_VERIFY_ALL: begin
          bad = (s.pidx != fvpc_pkg::PIDX_VERIFY_ALL);
          next_s.addr = fvpc_pkg::EE_BASE;
          next_s.last = fvpc_pkg::EE_LAST;
          next_s.two = 1'b1;
        end
        fvpc_pkg::CMD_VERIFY_BLOCK: begin
          bad = (s.pidx != fvpc_pkg::PIDX_VERIFY_BLOCK) || !(in_pf || in_ee);
          next_s.addr = in_pf ? fvpc_pkg::PF_BASE : fvpc_pkg::EE_BASE;
          next_s.last = in_pf ? fvpc_pkg::PF_LAST : fvpc_pkg::EE_LAST;
        end
        fvpc_pkg::CMD_VERIFY_SECTION: begin
          bad = (s.pidx != fvpc_pkg::PIDX_VERIFY_SECTION) || !s.mode_ok || !aligned || !in_pf
            || (s.p[2] == 16'h0000) || (sect_end > {1'b0, fvpc_pkg::PF_LAST});
          next_s.last = sect_end[23:0];
        end
        fvpc_pkg::CMD_READ_ONCE: begin
          bad = (s.pidx != fvpc_pkg::PIDX_READ_ONCE) || !s.mode_ok || (s.p[1] > fvpc_pkg::ONCE_LAST);
          next_s.op = fvpc_pkg::OP_ONCE;
          next_s.ifr = !bad;
          next_s.rd_inval = !bad;
          next_s.addr = {5'h00, s.p[1], 3'h0};
        end
        fvpc_pkg::CMD_PROGRAM: begin
          bad = (s.pidx != fvpc_pkg::PIDX_PROGRAM) || !s.mode_ok || !in_pf || !aligned;
          next_s.op = fvpc_pkg::OP_PROGRAM;
          next_s.st = fvpc_pkg::S_WRITE;
          if (!bad && s.prot_en && (gaddr[17:10] >= s.prot_floor)) begin
            next_s.pviol = 1'b1;
            next_s.st = fvpc_pkg::S_IDLE;
          end
        end
        default: bad = 1'b1;
      endcase
      if (bad) begin
        next_s.acc = 1'b1;
        next_s.st = fvpc_pkg::S_IDLE;
      end else if (next_s.st != fvpc_pkg::S_IDLE) begin
        next_s.ccf = 1'b0;
      end
    end
    case (s.st)
      fvpc_pkg::S_IDLE: begin
      end
      fvpc_pkg::S_WRITE: begin
        next_s.mem_wr = 1'b1;
        next_s.st = fvpc_pkg::S_READ;
      end
      fvpc_pkg::S_READ: begin
        next_s.mem_rd = 1'b1;
        next_s.st = fvpc_pkg::S_WAIT;
      end
      fvpc_pkg::S_WAIT: next_s.st = fvpc_pkg::S_EVAL;
      fvpc_pkg::S_EVAL: begin
        next_s.st = fvpc_pkg::S_IDLE;
        case (s.op)
          fvpc_pkg::OP_VERIFY: begin
            next_s.vf_any = s.vf_any | MEM_ERR | MEM_FATAL | blank_fail;
            next_s.vf_unc = s.vf_unc | MEM_FATAL | blank_fail;
            if (s.addr != s.last) begin
              next_s.addr = s.addr + fvpc_pkg::PHRASE_STEP;
              next_s.st = fvpc_pkg::S_READ;
            end else if (s.two) begin
              next_s.two = 1'b0;
              next_s.addr = fvpc_pkg::PF_BASE;
              next_s.last = fvpc_pkg::PF_LAST;
              next_s.st = fvpc_pkg::S_READ;
            end
          end
          fvpc_pkg::OP_ONCE: begin
            next_s.p[2] = MEM_RDATA[63:48];
            next_s.p[3] = MEM_RDATA[47:32];
            next_s.p[4] = MEM_RDATA[31:16];
            next_s.p[5] = MEM_RDATA[15:0];
            next_s.vf_any = MEM_ERR | MEM_FATAL;
            next_s.vf_unc = MEM_FATAL;
          end
          default: begin
            next_s.vf_any = MEM_ERR | MEM_FATAL | mismatch;
            next_s.vf_unc = MEM_FATAL;
          end
        endcase
        if (next_s.st == fvpc_pkg::S_IDLE) begin
          next_s.ccf = 1'b1;
          next_s.ifr = 1'b0;
          next_s.rd_inval = 1'b0;
        end
      end
      default: next_s.st = fvpc_pkg::S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s <= '0;
      s.st <= fvpc_pkg::S_IDLE;
      s.op <= fvpc_pkg::OP_VERIFY;
      s.ccf <= 1'b1;
      s.mode_ok <= fvpc_pkg::MODE_OK_RESET;
      s.prot_en <= fvpc_pkg::PROT_EN_RESET;
      s.prot_floor <= fvpc_pkg::PROT_FLOOR_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a field of the state register.
  assign RDATA = s.rdata;
  assign MEM_ADDR = s.addr;
  assign MEM_RD = s.mem_rd;
  assign MEM_WR = s.mem_wr;
  assign MEM_IFR = s.ifr;
  assign MEM_WDATA = {s.p[2], s.p[3], s.p[4], s.p[5]};
  assign READ_INVALID = s.rd_inval;
  assign CMD_DONE = s.ccf;

endmodule : fvpc_top
`default_nettype wire

/* tb/fvpc_mem_model.sv */
// Behavioural nonvolatile array answering the sequencer's memory link.
`timescale 1ns/1ns
`default_nettype none
module fvpc_mem_model (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic ifr,
  input wire logic [63:0] wdata,
  input wire logic inj_err,
  input wire logic inj_fatal,
  output logic [63:0] rdata,
  output logic err,
  output logic fatal
);
  // ---------------------------------------------------------------
  // Phrase store
  // ---------------------------------------------------------------
  logic [63:0] mem [logic [23:0]];
  initial {rdata, err, fatal} = '0;
  // Outside the answer cycle the lines toggle, so stale data never passes for an answer.
  always @(posedge clk) begin
    if (wr) mem[addr] = wdata;
    {rdata, err, fatal} <= ~{rdata, err, fatal};
    if (rd) begin
      rdata <= ifr ? {4{8'ha5, addr[7:0]}} : (mem.exists(addr) ? mem[addr] : '1);
      err <= inj_err;
      fatal <= inj_fatal;
    end
  end
endmodule : fvpc_mem_model
`default_nettype wire

/* tb/fvpc_monitor.sv */
// Port checker for the command sequencer, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module fvpc_monitor (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic [23:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic MEM_IFR,
  input wire logic READ_INVALID,
  input wire logic CMD_DONE
);
  // ---------------------------------------------------------------
  // Sequencing relations
  // ---------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic launch_wr;
  assign launch_wr = WR && ADDR == fvpc_pkg::ADDR_STATUS && WDATA[fvpc_pkg::BIT_CCF];
  sequence once_s;
    MEM_RD && MEM_IFR ##2 !READ_INVALID && !MEM_IFR;
  endsequence
  sequence readback_s;
    MEM_RD && $stable(MEM_ADDR);
  endsequence
  // The flag falls one edge after the launch write, yet a launch one or two edges back is accepted.
  launch_cause_a: assert property ($fell(CMD_DONE) |-> $past(launch_wr) || $past(launch_wr, 2))
    else $error("completion flag fell without a launch write");
  busy_quiet_a: assert property (MEM_RD || MEM_WR |-> !CMD_DONE)
    else $error("memory access while the completion flag is set");
  write_back_a: assert property (MEM_WR |=> readback_s)
    else $error("programmed phrase not read back at once");
  write_align_a: assert property (MEM_WR |-> MEM_ADDR[2:0] == 3'h0 && MEM_ADDR >= fvpc_pkg::PF_BASE)
    else $error("phrase write to a bad address");
  read_align_a: assert property (MEM_RD |-> MEM_ADDR[2:0] == 3'h0)
    else $error("phrase read misaligned");
  once_range_a: assert property (MEM_IFR |-> MEM_ADDR <= 24'h000038 && READ_INVALID)
    else $error("one-time row access out of range or unguarded");
  once_walk_a: assert property ($rose(READ_INVALID) |=> once_s)
    else $error("one-time read sequence wrong");
  read_space_a: assert property (MEM_RD |=> !MEM_RD [*2])
    else $error("phrase reads too close");
endmodule : fvpc_monitor
bind fvpc_top fvpc_monitor u_fvpc_monitor (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_IFR(MEM_IFR), .READ_INVALID(READ_INVALID),
  .CMD_DONE(CMD_DONE));
`default_nettype wire

/* tb/fvpc_tb_top.sv */
// Self-checking bench for the command sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module fvpc_tb_top;
  // ---------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic inj_err = 1'b0;
  logic inj_fatal = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [23:0] mem_addr;
  logic mem_rd, mem_wr, mem_ifr, mem_err, mem_fatal, read_invalid, cmd_done;
  logic [63:0] mem_wdata, mem_rdata;
  int miscompares = 0;
  int total_checks = 0;
  fvpc_top u_fvpc_top (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_IFR(mem_ifr),
    .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .MEM_ERR(mem_err), .MEM_FATAL(mem_fatal),
    .READ_INVALID(read_invalid), .CMD_DONE(cmd_done));
  fvpc_mem_model u_fvpc_mem_model (.clk(clk_sys), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr), .ifr(mem_ifr),
    .wdata(mem_wdata), .inj_err(inj_err), .inj_fatal(inj_fatal), .rdata(mem_rdata), .err(mem_err),
    .fatal(mem_fatal));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rreg
  // Loads n words, so the index at launch is n-1, then launches and checks status.
  task automatic cmd(input logic [15:0] p0, p1, p2, input int n, input logic [15:0] st);
    logic [15:0] p [6];
    int k;
    p = '{p0, p1, p2, 16'h5678, 16'h9abc, 16'hdef0};
    for (int i = 0; i < n; i++) begin
      wreg(4'h1, 16'(i));
      wreg(4'h2, p[i]);
    end
    wreg(4'h0, 16'h00b0);
    k = 0;
    while (cmd_done !== 1'b1 || k < 3) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k > 60000) begin
        miscompares++;
        wrap_up();
      end
    end
    rreg(4'h0, st);
  endtask : cmd
  task automatic t_program();
    rreg(4'h4, 16'h00ff);
    // Each phrase is programmed once, into erased space only.
    cmd(16'h06fe, 16'h0008, 16'h1234, 6, 16'h0080);
    `CHK(u_fvpc_mem_model.mem[24'hfe0008], 64'h123456789abcdef0)
    cmd(16'h06fe, 16'h0009, 16'h1234, 6, 16'h00a0);
    cmd(16'h06fe, 16'h0010, 16'h1234, 5, 16'h00a0);
    cmd(16'h0610, 16'h0000, 16'h1234, 6, 16'h00a0);
    wreg(4'h3, 16'h0003);
    wreg(4'h4, 16'h0000);
    cmd(16'h06fe, 16'h0010, 16'h1234, 6, 16'h0090);
    wreg(4'h3, 16'h0001);
    inj_err <= 1'b1;
    cmd(16'h06fe, 16'h0018, 16'h1234, 6, 16'h0082);
    inj_fatal <= 1'b1;
    cmd(16'h06fe, 16'h0020, 16'h1234, 6, 16'h0083);
    inj_err <= 1'b0;
    inj_fatal <= 1'b0;
  endtask : t_program
  task automatic t_once();
    // The bench, not code in the block being read, issues the one-time read.
    cmd(16'h0400, 16'h0007, 16'h0000, 2, 16'h0080);
    for (int i = 2; i < 6; i++) begin
      wreg(4'h1, 16'(i));
      rreg(4'h2, 16'ha538);
    end
    cmd(16'h0400, 16'h0008, 16'h0000, 2, 16'h00a0);
    cmd(16'h0400, 16'h0007, 16'h0000, 3, 16'h00a0);
    wreg(4'h3, 16'h0000);
    cmd(16'h0400, 16'h0007, 16'h0000, 2, 16'h00a0);
    cmd(16'h03fe, 16'h0010, 16'h0001, 3, 16'h00a0);
    wreg(4'h3, 16'h0001);
  endtask : t_once
  task automatic t_verify();
    cmd(16'h0210, 16'h0000, 16'h0000, 2, 16'h0080);
    cmd(16'h0220, 16'h0000, 16'h0000, 2, 16'h00a0);
    cmd(16'h0210, 16'h0000, 16'h0000, 1, 16'h00a0);
    cmd(16'h03fe, 16'h0008, 16'h0001, 3, 16'h0083);
    cmd(16'h03fe, 16'h0010, 16'h0001, 2, 16'h00a0);
    cmd(16'h03fe, 16'h0004, 16'h0001, 3, 16'h00a0);
    cmd(16'h03ff, 16'hfff8, 16'h0002, 3, 16'h00a0);
    inj_err <= 1'b1;
    cmd(16'h03fe, 16'h0010, 16'h0001, 3, 16'h0082);
    inj_err <= 1'b0;
    cmd(16'h0500, 16'h0000, 16'h0000, 1, 16'h00a0);
    cmd(16'h0100, 16'h0000, 16'h0000, 2, 16'h00a0);
    cmd(16'h0100, 16'h0000, 16'h0000, 1, 16'h0083);
  endtask : t_verify
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rreg(4'h0, 16'h0080);
    t_program();
    t_once();
    t_verify();
    wrap_up();
  end
endmodule : fvpc_tb_top
`default_nettype wire
